// File: src/eir_pkg.sv
// package for the external interrupt and reset pin block
// assumes one clock (ref_clk, 40 mhz) and a synchronous active-high reset
package eir_pkg;

  // =====================================================
  // timing
  // =====================================================
  localparam int unsigned CLK_PERIOD_NS = 25;
  // slowest acceptable processor clock period, as a time
  localparam int unsigned SLOW_LIMIT_NS = 2000;
  localparam int unsigned SLOW_LIMIT_CYC = SLOW_LIMIT_NS / CLK_PERIOD_NS;
  // minimum length the reset pin is driven low after an internal failure
  localparam int unsigned FAIL_PULSE_NS = 400;
  localparam int unsigned FAIL_PULSE_CYC = (FAIL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] SLOW_LIMIT_CNT = CNT_W'(SLOW_LIMIT_CYC);
  localparam logic [CNT_W-1:0] FAIL_PULSE_CNT = CNT_W'(FAIL_PULSE_CYC);

  // =====================================================
  // values after reset
  // =====================================================
  localparam logic MASK_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;

  // =====================================================
  // types
  // =====================================================
  typedef enum logic [2:0] {
    EIR_RUN = 3'h1,
    EIR_ENTRY = 3'h2,
    EIR_FAIL = 3'h4
  } eir_state_t;

  // cpu side handshake
  typedef struct packed {
    logic instr_done;
    logic mask_clear;
    logic mask_set;
    logic level_mode;
  } eir_cpu_t;

  // supervisor events
  typedef struct packed {
    logic watchdog_supervisor_fail;
    logic clock_monitor_fail;
  } eir_fail_t;

endpackage

// File: src/eir_sync.sv
// two flip-flop synchroniser for one asynchronous level
// assumes the input comes from a pin outside the clock domain
`timescale 1ns/1ps
module eir_sync
  import eir_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic async_in,
  input wire logic rst_val,
  output logic sync_out
);

  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb
  begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (clk_en)
    begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
    end
  end

  // rst_val is a tie-off constant at each instance
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_r <= rst_val;
      sync_r <= rst_val;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

// File: src/eir_top.sv
// external interrupt request and bidirectional reset pin logic
// assumes the cpu core reports instruction boundaries and mask instructions
`timescale 1ns/1ps
module eir_top
  import eir_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic irq_n_in,
  input wire logic rst_pin_n_in,
  input wire logic cpu_clk_tick,
  input wire eir_cpu_t cpu,
  input wire eir_fail_t fail_in,
  output logic rst_pin_n_out,
  output logic rst_pin_oe_n,
  output logic core_rst,
  output logic int_entry,
  output logic int_mask,
  output logic req_pending
);

  // =====================================================
  // synchronisers
  // =====================================================
  logic irq_s;
  logic rst_pin_s;
  logic tick_s;

  eir_sync u_irq_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(irq_n_in),
    .rst_val(1'b1),
    .sync_out(irq_s)
  );

  eir_sync u_rst_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(rst_pin_n_in),
    .rst_val(1'b1),
    .sync_out(rst_pin_s)
  );

  eir_sync u_tick_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(cpu_clk_tick),
    .rst_val(1'b0),
    .sync_out(tick_s)
  );

  // =====================================================
  // state
  // =====================================================
  eir_state_t state_r, state_nxt;
  logic irq_prev_r, irq_prev_nxt;
  logic tick_prev_r, tick_prev_nxt;
  logic latch_r, latch_nxt;
  logic mask_r, mask_nxt;
  logic entry_r, entry_nxt;
  logic core_rst_r, core_rst_nxt;
  logic drive_r, drive_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [CNT_W-1:0] mon_cnt_r, mon_cnt_nxt;
  logic [CNT_W-1:0] pulse_cnt_r, pulse_cnt_nxt;

  logic fall;
  logic set_req;
  logic take;
  logic clk_fail;
  logic any_fail;

  // one counter step shared by the clock monitor and the pulse timer
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] v, input logic up);
    cnt_step = up ? v + CNT_W'(1) : v - CNT_W'(1);
  endfunction

  // =====================================================
  // next values
  // =====================================================
  always_comb
  begin
    state_nxt = state_r;
    irq_prev_nxt = irq_prev_r;
    tick_prev_nxt = tick_prev_r;
    latch_nxt = latch_r;
    mask_nxt = mask_r;
    entry_nxt = entry_r;
    core_rst_nxt = core_rst_r;
    drive_nxt = drive_r;
    mon_cnt_nxt = mon_cnt_r;
    pulse_cnt_nxt = pulse_cnt_r;
    fall = irq_prev_r & ~irq_s;
    // edge-only mode sees falls; level mode adds a held low
    set_req = fall | (cpu.level_mode & ~irq_s);
    take = cpu.instr_done & latch_r & ~mask_r & (state_r == EIR_RUN);
    clk_fail = 1'b0;
    if (clk_en)
    begin
      entry_nxt = 1'b0;
      irq_prev_nxt = irq_s;
      tick_prev_nxt = tick_s;
      // a stopped or slow processor clock runs the monitor out
      if (tick_s != tick_prev_r)
        mon_cnt_nxt = '0;
      else if (mon_cnt_r != SLOW_LIMIT_CNT)
        mon_cnt_nxt = cnt_step(mon_cnt_r, 1'b1);
      clk_fail = fail_in.clock_monitor_fail | (mon_cnt_r == SLOW_LIMIT_CNT);
      any_fail = fail_in.watchdog_supervisor_fail | clk_fail;
      // software mask control; a new request wins over the entry clear
      if (cpu.mask_clear)
        mask_nxt = 1'b0;
      if (cpu.mask_set)
        mask_nxt = 1'b1;
      if (take)
        latch_nxt = 1'b0;
      if (set_req)
        latch_nxt = 1'b1;
      unique case (state_r)
        EIR_RUN:
        begin
          core_rst_nxt = 1'b0;
          if (take)
          begin
            entry_nxt = 1'b1;
            state_nxt = EIR_ENTRY;
          end
        end
        EIR_ENTRY:
        begin
          // registers are stacked by now; mask before the vector fetch
          mask_nxt = 1'b1;
          state_nxt = EIR_RUN;
        end
        EIR_FAIL:
        begin
          if (pulse_cnt_r != '0)
            pulse_cnt_nxt = cnt_step(pulse_cnt_r, 1'b0);
          else
          begin
            drive_nxt = 1'b0;
            state_nxt = EIR_RUN;
          end
        end
        default:
          state_nxt = EIR_RUN;
      endcase
      if (any_fail && state_r != EIR_FAIL)
      begin
        drive_nxt = 1'b1;
        pulse_cnt_nxt = FAIL_PULSE_CNT;
        state_nxt = EIR_FAIL;
        mon_cnt_nxt = '0;
      end
      // pin low, from outside or our own drive, holds the core in reset
      if (!rst_pin_s || drive_nxt)
      begin
        core_rst_nxt = 1'b1;
        mask_nxt = MASK_RST;
        latch_nxt = LATCH_RST;
        entry_nxt = 1'b0;
        if (state_nxt == EIR_ENTRY)
          state_nxt = EIR_RUN;
      end
    end
    else
      any_fail = 1'b0;
    // pin enable has its own flop so the output needs no gate
    oe_n_nxt = ~drive_nxt;
  end

  // =====================================================
  // registers
  // =====================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= EIR_RUN;
      irq_prev_r <= 1'b1;
      tick_prev_r <= 1'b0;
      latch_r <= LATCH_RST;
      mask_r <= MASK_RST;
      entry_r <= 1'b0;
      core_rst_r <= 1'b1;
      drive_r <= 1'b0;
      oe_n_r <= 1'b1;
      mon_cnt_r <= '0;
      pulse_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      irq_prev_r <= irq_prev_nxt;
      tick_prev_r <= tick_prev_nxt;
      latch_r <= latch_nxt;
      mask_r <= mask_nxt;
      entry_r <= entry_nxt;
      core_rst_r <= core_rst_nxt;
      drive_r <= drive_nxt;
      oe_n_r <= oe_n_nxt;
      mon_cnt_r <= mon_cnt_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // =====================================================
  // outputs
  // =====================================================
  // open drain: data is always low, enable low while pulling
  assign rst_pin_n_out = 1'b0;
  assign rst_pin_oe_n = oe_n_r;
  assign core_rst = core_rst_r;
  assign int_entry = entry_r;
  assign int_mask = mask_r;
  assign req_pending = latch_r;

endmodule

// File: test/eir_assertions.sv
// checks on the interrupt and reset pin block
// bound to eir_top; sees only its ports
`timescale 1ns/1ps
module eir_assertions
  import eir_pkg::*;
(
  input logic ref_clk,
  input logic sys_rst,
  input logic clk_en,
  input logic irq_n_in,
  input logic rst_pin_n_in,
  input eir_cpu_t cpu,
  input eir_fail_t fail_in,
  input logic rst_pin_oe_n,
  input logic core_rst,
  input logic int_entry,
  input logic int_mask,
  input logic req_pending
);
  // counts samples with the reset pin driven, so the pulse length can be judged
  logic [7:0] lo_r, lo_nxt;
  always_comb
  begin
    lo_nxt = rst_pin_oe_n ? 8'h00 : lo_r + 8'h01;
  end
  always_ff @(posedge ref_clk)
  begin
    lo_r <= sys_rst ? 8'h00 : lo_nxt;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  sequence irq_fall;
    $fell(irq_n_in) ##1 !irq_n_in [*2];
  endsequence
  a_irq_latched: assert property (irq_fall |-> ##[0:2] req_pending)
    else $error("latch not set");
  a_entry_start: assert property (cpu.instr_done && req_pending && !int_mask && !core_rst |=> int_entry)
    else $error("no entry");
  a_entry_masks: assert property (int_entry |=> int_mask)
    else $error("mask not set");
  a_masked_kept: assert property (req_pending && int_mask && rst_pin_n_in && fail_in == '0 |=> req_pending)
    else $error("request lost");
  a_edge_clear: assert property (int_entry && !cpu.level_mode |-> !req_pending)
    else $error("latch not cleared");
  a_level_repend: assert property ((cpu.level_mode && !irq_n_in) [*5] ##0 int_entry |-> req_pending)
    else $error("level lost");
  a_fail_length: assert property ($rose(rst_pin_oe_n) |-> lo_r == FAIL_PULSE_CNT + 8'h01)
    else $error("pulse length");
  a_pin_reset: assert property (!rst_pin_n_in [*5] |-> core_rst && int_mask && !req_pending)
    else $error("pin reset");
endmodule
bind eir_top eir_assertions eir_assertions_i (.*);

// File: test/eir_pins.sv
// far side: interrupt source and reset circuit, both wires pulled up
// the device's open drain joins the reset wire here
`timescale 1ns/1ps
module eir_pins
(
  input logic irq_pull,
  input logic rst_pull,
  input logic rst_pin_oe_n,
  input logic rst_pin_n_out,
  output logic irq_n_in,
  output logic rst_pin_n_in
);
  assign irq_n_in = !irq_pull;
  assign rst_pin_n_in = !rst_pull && (rst_pin_oe_n || rst_pin_n_out);
endmodule

// File: test/eir_top_test.sv
// bench for eir_top with a model of the mask flag and request latch
// 40 mhz clock; pins come from the eir_pins model
`timescale 1ns/1ps
module eir_top_test
  import eir_pkg::*;
;
  logic ref_clk = 0, sys_rst = 1, irq_pull = 0, rst_pull = 0, cpu_clk_tick = 0, run = 1, clk_en = 1;
  logic irq_n_in, rst_pin_n_in, rst_pin_oe_n, rst_pin_n_out, core_rst, int_entry, int_mask, req_pending;
  eir_cpu_t cpu = '0;
  eir_fail_t fail_in = '0;
  int failures = 0, compares = 0, ticks = 0, mask_m = 1, pend_m = 0, n;
  eir_top eir_top_i (.*);
  eir_pins eir_pins_i (.*);
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cpu_clk_tick <= cpu_clk_tick ^ run;
    ticks++;
    if (ticks > 3000)
    begin
      failures++;
      final_report;
    end
  end
  task chk(string s, logic v, logic e);
    compares++;
    if (v !== e)
    begin
      failures++;
      $display("BAD %s exp %b seen %b", s, e, v);
    end
  endtask
  task cyc(int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // 8 = boundary, 4 = mask clear; outputs are read as sampled at the edge
  task pulse(logic [3:0] p);
    cpu <= eir_cpu_t'(cpu | p);
    cyc(1);
    cpu <= eir_cpu_t'(cpu & ~p);
    cyc(1);
  endtask
  task model;
    chk("mask", int_mask, mask_m[0]);
    chk("pend", req_pending, pend_m[0]);
  endtask
  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    n = $urandom(77180);
    cyc(10);
    model;
    sys_rst <= 0;
    cyc(4);
    chk("core", core_rst, 1'b0);
    irq_pull <= 1;
    cyc(6 + $urandom % 4);
    pend_m = 1;
    pulse(4'h8);
    chk("ent", int_entry, 1'b0);
    model;
    pulse(4'h4);
    mask_m = 0;
    chk("ent", int_entry, 1'b0);
    model;
    pulse(4'h8);
    chk("ent", int_entry, 1'b1);
    cyc(1);
    mask_m = 1;
    pend_m = 0;
    model;
    cpu.level_mode <= 1;
    cyc(5);
    pend_m = 1;
    model;
    pulse(4'h4);
    pulse(4'h8);
    chk("pend", req_pending, 1'b1);
    irq_pull <= 0;
    cpu.level_mode <= 0;
    cyc(1);
    pulse(4'h4);
    pulse(4'h8);
    chk("ent", int_entry, 1'b1);
    cyc(1);
    pend_m = 0;
    model;
    // clock monitor flag, watchdog, then a stopped processor clock
    for (int i = 0; i < 3; i++)
    begin
      fail_in <= eir_fail_t'(i < 2 ? 2'h1 << i : 2'h0);
      run <= i < 2;
      for (n = 0; rst_pin_oe_n && n < 200; n++) cyc(1);
      chk("core", core_rst, 1'b1);
      fail_in <= '0;
      run <= 1;
      for (n = 0; !rst_pin_oe_n && n < 40; n++) cyc(1);
      chk("len", n == FAIL_PULSE_CNT + 1, 1'b1);
    end
    cyc(6);
    chk("odat", rst_pin_n_out, 1'b0);
    pulse(4'h4);
    mask_m = 0;
    model;
    // set and clear together: set wins
    pulse(4'h6);
    mask_m = 1;
    model;
    pulse(4'h4);
    mask_m = 0;
    model;
    rst_pull <= 1;
    cyc(6);
    mask_m = 1;
    model;
    chk("core", core_rst, 1'b1);
    rst_pull <= 0;
    cyc(6);
    chk("core", core_rst, 1'b0);
    // frozen clock enable: the pin fall is only seen once enabled
    clk_en <= 0;
    irq_pull <= 1;
    cyc(8);
    model;
    clk_en <= 1;
    cyc(5);
    pend_m = 1;
    model;
    final_report;
  end
endmodule
